// *** pkg/pmicpl_defines.svh ***
// Timing, address and reset constants of the control-pin logic.
`ifndef PMICPL_DEFINES_SVH
`define PMICPL_DEFINES_SVH
`define PMICPL_CLK_MHZ      125
`define PMICPL_NREG         3
`define PMICPL_TEST_US      100
`define PMICPL_WDI_DBNC_US  10
`define PMICPL_FS_PRE_US    20
`define PMICPL_FS_DBNC_US   20
`define PMICPL_FS_HOLD_US   30
`define PMICPL_TEST_CYC     (`PMICPL_TEST_US * `PMICPL_CLK_MHZ)
`define PMICPL_WDI_DBNC_CYC (`PMICPL_WDI_DBNC_US * `PMICPL_CLK_MHZ)
`define PMICPL_FS_PRE_CYC   (`PMICPL_FS_PRE_US * `PMICPL_CLK_MHZ)
`define PMICPL_FS_DBNC_CYC  (`PMICPL_FS_DBNC_US * `PMICPL_CLK_MHZ)
`define PMICPL_FS_HOLD_CYC  (`PMICPL_FS_HOLD_US * `PMICPL_CLK_MHZ)
`define PMICPL_CFG_ADDR     7'h08
`define PMICPL_ADDR_BASE    4'h1
`define PMICPL_RST_PIN_LOW  1'b1
`endif

// *** pkg/pmicpl_pkg.sv ***
// Types shared by the control-pin logic and its users.
`include "pmicpl_defines.svh"
package pmicpl_pkg;
  typedef enum logic [4:0] {
    PMICPL_SYS_OFF   = 5'h01,
    PMICPL_SYS_PWRUP = 5'h02,
    PMICPL_SYS_ON    = 5'h04,
    PMICPL_SYS_STBY  = 5'h08,
    PMICPL_SYS_PWRDN = 5'h10
  } pmicpl_sys_type;
  typedef enum logic [4:0] {
    PMICPL_FS_IDLE = 5'h01,
    PMICPL_FS_PRE  = 5'h02,
    PMICPL_FS_DOWN = 5'h04,
    PMICPL_FS_HOLD = 5'h08,
    PMICPL_FS_WAIT = 5'h10
  } pmicpl_fs_type;
  typedef struct packed {
    logic [`PMICPL_NREG-1:0] enabled;
    logic [`PMICPL_NREG-1:0] over;
    logic [`PMICPL_NREG-1:0] under;
  } pmicpl_mon_type;
  typedef struct packed {
    logic write;
    logic run_level;
    logic standby_level;
  } pmicpl_gpo_type;
  typedef struct packed {
    logic write;
    logic action;
    logic in_standby;
  } pmicpl_wdcfg_type;
endpackage

// *** src/pmicpl_top.sv ***
// Control-pin logic: interrupt pin, watchdog input, power-good pins, enables, strap, fail sync.
`timescale 1ns/100ps
`include "pmicpl_defines.svh"

// Notes on behaviour
// - Interrupt pin low while unmasked latch set.
// - Self-test pulses interrupt pin, then self-clears.
// - Watchdog input watched only after reset release.
// - Polarity bit picks falling or rising edge.
// - Watchdog edge must hold through debounce.
// - Action bit picks hard or soft reset.
// - Standby bit gates watchdog input in standby.
// - General-output mode drives run/standby levels.
// - Output levels load from sequencing slot.
// - Window fault pulls pin low, latches interrupt.
// - Disabled regulators never affect combined pin.
// - Combined pin low until reset ready.
// - Per-regulator pin low on own fault.
// - Enable inputs frozen while sequencing runs.
// - Enable level readable as status flag.
// - Strap fixes address, stops watchdog, protections unless power-on event.
// - Fail sync disabled: ignore, drive only in reset.
// - Internal turn-off drives fail sync early.
// - Fail sync held low in Off until turn-on ready.
// - Debounced external low in On starts power-down.
// - Power-up stalls while others hold low.
// - Hard reset: hold, reload, release, wait.
// - Reset release gates the On state.
module pmicpl_top #(
  parameter int TEST_CYCLES = `PMICPL_TEST_CYC
) (
  // Clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          reset_n,
  // Sequencer status
  input  wire pmicpl_pkg::pmicpl_sys_type    sys_state,
  input  wire logic                          processor_reset_ready,
  input  wire logic                          processor_reset_n,
  input  wire logic                          turn_on_ready,
  input  wire logic                          power_on_event,
  input  wire logic                          outputs_off,
  input  wire logic                          internal_turn_off,
  // Interrupt pin
  input  wire logic                          irq_pending,
  input  wire logic                          irq_selftest_write,
  output logic                               irq_out_n_oe,
  output logic                               irq_pin_selftest,
  // Watchdog input
  input  wire logic                          watchdog_input,
  input  wire logic                          nv_watchdog_input_polarity,
  input  wire logic                          nv_watchdog_input_action,
  input  wire logic                          nv_watchdog_input_in_standby,
  input  wire pmicpl_pkg::pmicpl_wdcfg_type  wd_cfg,
  output logic                               watchdog_input_action,
  output logic                               watchdog_input_in_standby,
  output logic                               watchdog_hard_reset,
  output logic                               watchdog_soft_reset,
  // Power-good pins
  input  wire logic                          nv_power_ok_mode,
  input  wire logic                          nv_power_ok_slot,
  input  wire pmicpl_pkg::pmicpl_mon_type    mon,
  input  wire pmicpl_pkg::pmicpl_gpo_type    gpo,
  output logic                               power_ok_out_oe,
  output logic [`PMICPL_NREG-1:0]            regulator_ok_out_oe,
  output logic [`PMICPL_NREG-1:0]            overvoltage_live,
  output logic [`PMICPL_NREG-1:0]            undervoltage_live,
  output logic [`PMICPL_NREG-1:0]            ovuv_irq_set,
  output logic                               powerup_fault,
  output logic                               run_general_out_level,
  output logic                               standby_general_out_level,
  // Regulator enables
  input  wire logic [`PMICPL_NREG-1:0]       regulator_enable_in,
  output logic [`PMICPL_NREG-1:0]            regulator_enable_level_flag,
  output logic [`PMICPL_NREG-1:0]            regulator_on_request,
  // Configuration strap
  input  wire logic                          config_mode_strap,
  input  wire logic [2:0]                    nv_serial_address,
  output logic                               config_mode,
  output logic [6:0]                         serial_address,
  output logic                               protections_off,
  // Fail synchronisation
  input  wire logic                          nv_fail_sync_enable,
  input  wire logic                          fail_sync_pin_in,
  output logic                               fail_sync_pin_oe,
  output logic                               power_down_start,
  output logic                               fail_event,
  output logic                               powerup_stall,
  output logic                               nv_reload
);

  localparam int TW = $clog2(TEST_CYCLES + 1);
  localparam logic [TW-1:0] TEST_END = TW'(TEST_CYCLES - 1);
  localparam logic [11:0] WDI_END = 12'(`PMICPL_WDI_DBNC_CYC - 1);
  localparam logic [11:0] PRE_END = 12'(`PMICPL_FS_PRE_CYC - 1);
  localparam logic [11:0] DBNC_END = 12'(`PMICPL_FS_DBNC_CYC - 1);
  localparam logic [11:0] HOLD_END = 12'(`PMICPL_FS_HOLD_CYC - 1);

  logic                      st_on, st_off, st_stby, st_pwrup, seq_active;
  logic                      nv_load_pending, nv_load;
  logic [TW-1:0]             test_cnt;
  logic                      wdi_q, wdi_armed, wdi_active, wdi_edge, wdi_fire;
  logic [11:0]               wdi_cnt;
  logic                      pg_unmasked, pg_fault;
  logic [`PMICPL_NREG-1:0]   ov_now, uv_now;
  pmicpl_pkg::pmicpl_fs_type fs;
  logic [11:0]               fs_cnt;
  logic                      fs_hard, int_off, next_fs_drive;

  assign st_on      = sys_state == pmicpl_pkg::PMICPL_SYS_ON;
  assign st_off     = sys_state == pmicpl_pkg::PMICPL_SYS_OFF;
  assign st_stby    = sys_state == pmicpl_pkg::PMICPL_SYS_STBY;
  assign st_pwrup   = sys_state == pmicpl_pkg::PMICPL_SYS_PWRUP;
  assign seq_active = st_pwrup | (sys_state == pmicpl_pkg::PMICPL_SYS_PWRDN);
  assign nv_load    = nv_load_pending | nv_reload;

  //--------------------------------------------------------------------------
  // Nonvolatile defaults and software-written control bits
  //--------------------------------------------------------------------------
  // Defaults are taken one cycle after reset release, since reset itself may only load constants.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      nv_load_pending           <= 1'b1;
      watchdog_input_action     <= 1'b0;
      watchdog_input_in_standby <= 1'b0;
      run_general_out_level     <= 1'b0;
      standby_general_out_level <= 1'b0;
    end else begin
      nv_load_pending <= 1'b0;
      if (nv_load) begin
        watchdog_input_action     <= nv_watchdog_input_action;
        watchdog_input_in_standby <= nv_watchdog_input_in_standby;
        run_general_out_level     <= nv_power_ok_slot;
        standby_general_out_level <= nv_power_ok_slot;
      end else begin
        if (wd_cfg.write) begin
          watchdog_input_action     <= wd_cfg.action;
          watchdog_input_in_standby <= wd_cfg.in_standby;
        end
        if (gpo.write) begin
          run_general_out_level     <= gpo.run_level;
          standby_general_out_level <= gpo.standby_level;
        end
      end
    end
  end

  //--------------------------------------------------------------------------
  // Interrupt pin and its self-test pulse
  //--------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_pin_selftest <= 1'b0;
      test_cnt         <= '0;
      irq_out_n_oe     <= 1'b0;
    end else begin
      irq_out_n_oe <= irq_pending | irq_pin_selftest;
      if (irq_pin_selftest) begin
        if (test_cnt == TEST_END) begin
          irq_pin_selftest <= 1'b0;
          test_cnt         <= '0;
        end else begin
          test_cnt <= test_cnt + 1'b1;
        end
      end else if (irq_selftest_write) begin
        irq_pin_selftest <= 1'b1;
      end
    end
  end

  //--------------------------------------------------------------------------
  // Watchdog input edge, debounce and action
  //--------------------------------------------------------------------------
  assign wdi_active = !config_mode & processor_reset_n &
                      (st_on | (st_stby & watchdog_input_in_standby));
  // The first sample after reset has no valid history, so no edge is taken from it.
  assign wdi_edge   = (watchdog_input == nv_watchdog_input_polarity) &
                      (wdi_q != nv_watchdog_input_polarity) & !nv_load_pending;
  assign wdi_fire   = wdi_armed & (watchdog_input == nv_watchdog_input_polarity) & (wdi_cnt == WDI_END);

  // A glitch that falls back before the debounce ends simply disarms the filter.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wdi_q               <= 1'b0;
      wdi_armed           <= 1'b0;
      wdi_cnt             <= '0;
      watchdog_hard_reset <= 1'b0;
      watchdog_soft_reset <= 1'b0;
    end else begin
      wdi_q               <= watchdog_input;
      watchdog_hard_reset <= wdi_active & wdi_fire & watchdog_input_action;
      watchdog_soft_reset <= wdi_active & wdi_fire & !watchdog_input_action;
      if (!wdi_active || wdi_edge) begin
        wdi_armed <= wdi_active;
        wdi_cnt   <= '0;
      end else if (wdi_armed) begin
        if (watchdog_input != nv_watchdog_input_polarity || wdi_fire) begin
          wdi_armed <= 1'b0;
        end
        wdi_cnt <= wdi_cnt + 12'h001;
      end
    end
  end

  //--------------------------------------------------------------------------
  // Power-good pins, live status and enables
  //--------------------------------------------------------------------------
  assign ov_now   = mon.enabled & mon.over;
  assign uv_now   = mon.enabled & mon.under;
  assign pg_fault = |(ov_now | uv_now);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pg_unmasked     <= 1'b0;
      powerup_fault   <= 1'b0;
      power_ok_out_oe <= `PMICPL_RST_PIN_LOW;
    end else begin
      powerup_fault <= 1'b0;
      if (st_off) begin
        pg_unmasked <= 1'b0;
      end else if (st_pwrup && processor_reset_ready && !pg_unmasked) begin
        pg_unmasked   <= 1'b1;
        powerup_fault <= pg_fault;
      end
      if (!nv_power_ok_mode) begin
        power_ok_out_oe <= st_stby ? !standby_general_out_level : !run_general_out_level;
      end else begin
        power_ok_out_oe <= !pg_unmasked | pg_fault;
      end
    end
  end

  for (genvar i = 0; i < `PMICPL_NREG; i++) begin : g_reg
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        regulator_ok_out_oe[i]         <= `PMICPL_RST_PIN_LOW;
        overvoltage_live[i]            <= 1'b0;
        undervoltage_live[i]           <= 1'b0;
        ovuv_irq_set[i]                <= 1'b0;
        regulator_enable_level_flag[i] <= 1'b0;
        regulator_on_request[i]        <= 1'b0;
      end else begin
        regulator_ok_out_oe[i]         <= mon.over[i] | mon.under[i];
        overvoltage_live[i]            <= ov_now[i];
        undervoltage_live[i]           <= uv_now[i];
        ovuv_irq_set[i]                <= (ov_now[i] & !overvoltage_live[i]) |
                                          (uv_now[i] & !undervoltage_live[i]);
        regulator_enable_level_flag[i] <= regulator_enable_in[i];
        if (!seq_active) begin
          regulator_on_request[i] <= regulator_enable_in[i];
        end
      end
    end
  end

  //--------------------------------------------------------------------------
  // Configuration strap
  //--------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      config_mode     <= 1'b0;
      serial_address  <= `PMICPL_CFG_ADDR;
      protections_off <= 1'b0;
    end else begin
      config_mode     <= config_mode_strap;
      serial_address  <= config_mode_strap ? `PMICPL_CFG_ADDR : {`PMICPL_ADDR_BASE, nv_serial_address};
      protections_off <= config_mode_strap & !power_on_event;
    end
  end

  //--------------------------------------------------------------------------
  // Fail synchronisation pin
  //--------------------------------------------------------------------------
  assign int_off       = internal_turn_off | watchdog_hard_reset;
  assign next_fs_drive = nv_fail_sync_enable &
                         ((fs == pmicpl_pkg::PMICPL_FS_PRE) | (fs == pmicpl_pkg::PMICPL_FS_DOWN) |
                          (fs == pmicpl_pkg::PMICPL_FS_HOLD) |
                          ((fs == pmicpl_pkg::PMICPL_FS_IDLE) & st_off & !turn_on_ready));

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fs               <= pmicpl_pkg::PMICPL_FS_IDLE;
      fs_cnt           <= '0;
      fs_hard          <= 1'b0;
      power_down_start <= 1'b0;
      fail_event       <= 1'b0;
      nv_reload        <= 1'b0;
    end else begin
      power_down_start <= 1'b0;
      fail_event       <= 1'b0;
      nv_reload        <= 1'b0;
      if (!nv_fail_sync_enable) begin
        fs               <= pmicpl_pkg::PMICPL_FS_IDLE;
        fs_cnt           <= '0;
        power_down_start <= int_off;
      end else begin
        unique case (fs)
          pmicpl_pkg::PMICPL_FS_IDLE: begin
            if (int_off) begin
              fs      <= pmicpl_pkg::PMICPL_FS_PRE;
              fs_cnt  <= '0;
              fs_hard <= watchdog_hard_reset;
            end else if (st_on && !fail_sync_pin_in) begin
              fs_cnt <= fs_cnt + 12'h001;
              if (fs_cnt == DBNC_END) begin
                fs               <= pmicpl_pkg::PMICPL_FS_DOWN;
                fail_event       <= 1'b1;
                power_down_start <= 1'b1;
                fs_hard          <= 1'b0;
              end
            end else begin
              fs_cnt <= '0;
            end
          end
          pmicpl_pkg::PMICPL_FS_PRE: begin
            fs_cnt <= fs_cnt + 12'h001;
            if (fs_cnt == PRE_END) begin
              fs               <= pmicpl_pkg::PMICPL_FS_DOWN;
              power_down_start <= 1'b1;
            end
          end
          pmicpl_pkg::PMICPL_FS_DOWN: begin
            fs_cnt <= '0;
            if (outputs_off) begin
              fs <= fs_hard ? pmicpl_pkg::PMICPL_FS_HOLD : pmicpl_pkg::PMICPL_FS_IDLE;
            end
          end
          pmicpl_pkg::PMICPL_FS_HOLD: begin
            fs_cnt <= fs_cnt + 12'h001;
            if (fs_cnt == HOLD_END) begin
              fs        <= pmicpl_pkg::PMICPL_FS_WAIT;
              nv_reload <= 1'b1;
            end
          end
          pmicpl_pkg::PMICPL_FS_WAIT: begin
            if (fail_sync_pin_in) begin
              fs <= pmicpl_pkg::PMICPL_FS_IDLE;
            end
          end
          default: begin
            fs <= pmicpl_pkg::PMICPL_FS_IDLE;
          end
        endcase
      end
    end
  end

  // Own drive is excluded so that the device never stalls on its own low.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fail_sync_pin_oe <= `PMICPL_RST_PIN_LOW;
      powerup_stall    <= 1'b0;
    end else begin
      fail_sync_pin_oe <= next_fs_drive;
      powerup_stall    <= nv_fail_sync_enable & !fail_sync_pin_in & !fail_sync_pin_oe &
                          (st_pwrup | turn_on_ready | (fs == pmicpl_pkg::PMICPL_FS_WAIT));
    end
  end

  //--------------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence fs_pre_done_s;
    fs == pmicpl_pkg::PMICPL_FS_PRE && fs_cnt == PRE_END && nv_fail_sync_enable;
  endsequence
  sequence fs_hold_done_s;
    fs == pmicpl_pkg::PMICPL_FS_HOLD && fs_cnt == HOLD_END && nv_fail_sync_enable;
  endsequence

  irq_level_a: assert property (irq_pending |=> irq_out_n_oe) else $error("irq pin not low");
  test_clear_a: assert property (irq_pin_selftest && test_cnt == TEST_END |=> !irq_pin_selftest)
    else $error("self-test did not clear");
  test_hold_a: assert property ($rose(irq_pin_selftest) |=> irq_out_n_oe [*8]) else $error("test pulse short");
  wdi_gate_a: assert property ((watchdog_hard_reset || watchdog_soft_reset) |-> $past(wdi_active) && !$past(config_mode))
    else $error("watchdog event while masked");
  wdi_kind_a: assert property (wdi_active && wdi_fire |=> watchdog_hard_reset == $past(watchdog_input_action) &&
                               watchdog_soft_reset != $past(watchdog_input_action)) else $error("wrong reset kind");
  enable_freeze_a: assert property (seq_active |=> regulator_on_request == $past(regulator_on_request))
    else $error("enable changed in sequence");
  enable_flag_a: assert property (1'b1 |=> regulator_enable_level_flag == $past(regulator_enable_in))
    else $error("enable flag wrong");
  pg_off_low_a: assert property (st_off && nv_power_ok_mode ##1 nv_power_ok_mode |=> power_ok_out_oe)
    else $error("power ok released in off");
  fs_disabled_a: assert property (!nv_fail_sync_enable ##1 !nv_fail_sync_enable |-> !fail_sync_pin_oe)
    else $error("fail sync driven while off");
  fs_pre_a: assert property (fs_pre_done_s |=> power_down_start && fail_sync_pin_oe) else $error("pre-drive timing");
  fs_hold_a: assert property (fs_hold_done_s |=> nv_reload ##1 !fail_sync_pin_oe) else $error("hold release timing");

endmodule

// *** verif/pmicpl_peer_model.sv ***
// Peer power IC and pull-up on the shared fail-synchronisation wire.
`timescale 1ns/100ps
module pmicpl_peer_model (
  // Pin sinks
  input  wire logic hold_low,
  input  wire logic dut_oe,
  // Resolved wire
  output logic      pin_level
);
  // The wire has a pull-up, so it reads high unless some party sinks it.
  assign pin_level = !(hold_low || dut_oe);
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the control-pin logic.
`timescale 1ns/100ps
module testbench;
  logic ref_clk, reset_n, processor_reset_ready, processor_reset_n, turn_on_ready, power_on_event;
  logic outputs_off, internal_turn_off, irq_pending, irq_selftest_write, irq_out_n_oe, irq_pin_selftest;
  logic watchdog_input, nv_watchdog_input_polarity, nv_watchdog_input_action, nv_watchdog_input_in_standby;
  logic watchdog_input_action, watchdog_input_in_standby, watchdog_hard_reset, watchdog_soft_reset;
  logic nv_power_ok_mode, nv_power_ok_slot, power_ok_out_oe, powerup_fault, run_general_out_level;
  logic standby_general_out_level, config_mode_strap, config_mode, protections_off, nv_fail_sync_enable;
  logic fail_sync_pin_in, fail_sync_pin_oe, power_down_start, fail_event, powerup_stall, nv_reload, peer_hold;
  logic [2:0] regulator_ok_out_oe, overvoltage_live, undervoltage_live, ovuv_irq_set, nv_serial_address;
  logic [2:0] regulator_enable_in, regulator_enable_level_flag, regulator_on_request;
  logic [6:0] serial_address;
  logic       h, s, f;
  int         error_cnt, num_checks, i;
  pmicpl_pkg::pmicpl_sys_type   sys_state;
  pmicpl_pkg::pmicpl_wdcfg_type wd_cfg;
  pmicpl_pkg::pmicpl_mon_type   mon;
  pmicpl_pkg::pmicpl_gpo_type   gpo;

  pmicpl_top #(.TEST_CYCLES(16)) u_dut (.ref_clk, .reset_n, .sys_state, .processor_reset_ready,
    .processor_reset_n, .turn_on_ready, .power_on_event, .outputs_off, .internal_turn_off, .irq_pending,
    .irq_selftest_write, .irq_out_n_oe, .irq_pin_selftest, .watchdog_input, .nv_watchdog_input_polarity,
    .nv_watchdog_input_action, .nv_watchdog_input_in_standby, .wd_cfg, .watchdog_input_action,
    .watchdog_input_in_standby, .watchdog_hard_reset, .watchdog_soft_reset, .nv_power_ok_mode, .nv_power_ok_slot,
    .mon, .gpo, .power_ok_out_oe, .regulator_ok_out_oe, .overvoltage_live, .undervoltage_live, .ovuv_irq_set,
    .powerup_fault, .run_general_out_level, .standby_general_out_level, .regulator_enable_in,
    .regulator_enable_level_flag, .regulator_on_request, .config_mode_strap, .nv_serial_address, .config_mode,
    .serial_address, .protections_off, .nv_fail_sync_enable, .fail_sync_pin_in, .fail_sync_pin_oe,
    .power_down_start, .fail_event, .powerup_stall, .nv_reload);

  pmicpl_peer_model u_peer (.hold_low(peer_hold), .dut_oe(fail_sync_pin_oe), .pin_level(fail_sync_pin_in));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [6:0] exp, input logic [6:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Inputs always change 1 ns after the rising edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic do_reset;
    reset_n = 1'b0;
    cyc(8);
    chk("power_ok_out_oe", 7'h01, power_ok_out_oe);
    chk("fail_sync_pin_oe", 7'h01, fail_sync_pin_oe);
    reset_n = 1'b1;
    cyc(2);
  endtask

  // Pulses last one cycle, so every cycle is sampled and accumulated.
  task automatic watch(input int n);
    h = 1'b0;
    s = 1'b0;
    f = 1'b0;
    repeat (n) begin
      cyc(1);
      h |= watchdog_hard_reset;
      s |= watchdog_soft_reset;
      f |= fail_event;
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    {processor_reset_ready, power_on_event, outputs_off, internal_turn_off, irq_pending} = 5'h00;
    {irq_selftest_write, nv_watchdog_input_in_standby, nv_power_ok_mode, nv_power_ok_slot} = 4'h0;
    {config_mode_strap, nv_fail_sync_enable, peer_hold, turn_on_ready} = 4'h0;
    {nv_watchdog_input_polarity, nv_watchdog_input_action, processor_reset_n, watchdog_input} = 4'h3;
    {nv_serial_address, regulator_enable_in} = 6'h00;
    {wd_cfg, gpo, mon} = 15'h0000;
    sys_state = pmicpl_pkg::PMICPL_SYS_ON;
    {reset_n, error_cnt, num_checks} = '0;
    do_reset();
    regulator_enable_in = 3'h5;
    mon = '{enabled: 3'h3, over: 3'h2, under: 3'h4};
    cyc(1);
    chk("ovuv_set", 7'h02, ovuv_irq_set);
    cyc(2);
    chk("enable_flag", 7'h05, regulator_enable_level_flag);
    chk("regulator_ok_oe", 7'h06, regulator_ok_out_oe);
    chk("overvoltage_live", 7'h02, overvoltage_live);
    chk("undervoltage_live", 7'h00, undervoltage_live);
    chk("on_request", 7'h05, regulator_on_request);
    mon = '0;
    irq_pending = 1'b1;
    cyc(2);
    chk("irq_oe_pending", 7'h01, irq_out_n_oe);
    irq_pending = 1'b0;
    cyc(2);
    chk("irq_oe_cleared", 7'h00, irq_out_n_oe);
    irq_selftest_write = 1'b1;
    cyc(1);
    irq_selftest_write = 1'b0;
    cyc(13);
    chk("selftest_bit", 7'h01, irq_pin_selftest);
    chk("irq_oe_test", 7'h01, irq_out_n_oe);
    cyc(5);
    chk("selftest_clear", 7'h00, irq_pin_selftest);
    chk("irq_oe_after", 7'h00, irq_out_n_oe);
    $display("test pins and interrupt done");
    // Soft on falling edge, hard on rising edge, then standby with the input gated off.
    for (i = 0; i < 3; i++) begin
      nv_watchdog_input_polarity = i[0];
      nv_watchdog_input_action = i[0];
      sys_state = (i == 2) ? pmicpl_pkg::PMICPL_SYS_STBY : pmicpl_pkg::PMICPL_SYS_ON;
      watchdog_input = !i[0];
      do_reset();
      chk("action_bit", {6'h00, i[0]}, watchdog_input_action);
      watchdog_input = i[0];
      cyc(100);
      watchdog_input = !i[0];
      watch(1400);
      chk("glitch_event", 7'h00, {h, s});
      watchdog_input = i[0];
      watch(1300);
      chk("wd_hard", {6'h00, i == 1}, h);
      chk("wd_soft", {6'h00, i == 0}, s);
    end
    $display("test watchdog done");
    sys_state = pmicpl_pkg::PMICPL_SYS_ON;
    nv_fail_sync_enable = 1'b1;
    do_reset();
    cyc(4);
    chk("fs_oe_idle", 7'h00, fail_sync_pin_oe);
    peer_hold = 1'b1;
    watch(2600);
    peer_hold = 1'b0;
    chk("fail_event", 7'h01, f);
    chk("fs_oe_own", 7'h01, fail_sync_pin_oe);
    do_reset();
    internal_turn_off = 1'b1;
    cyc(1);
    internal_turn_off = 1'b0;
    cyc(2);
    chk("fs_oe_pre", 7'h01, fail_sync_pin_oe);
    $display("test fail sync done");
    config_mode_strap = 1'b1;
    nv_serial_address = 3'h5;
    cyc(2);
    chk("config_mode", 7'h01, config_mode);
    chk("strap_addr", 7'h08, serial_address);
    chk("prot_off", 7'h01, protections_off);
    config_mode_strap = 1'b0;
    cyc(2);
    chk("normal_addr", 7'h0D, serial_address);
    $display("test strap done");
    do_reset();
    wd_cfg = '{write: 1'b1, action: 1'b1, in_standby: 1'b1};
    watchdog_input = 1'b1;
    cyc(1);
    wd_cfg = '0;
    cyc(1);
    chk("wd_cfg", 7'h03, {watchdog_input_action, watchdog_input_in_standby});
    watchdog_input = 1'b0;
    outputs_off = 1'b1;
    watch(1300);
    chk("wd_hard_fs", 7'h01, h);
    cyc(6300);
    chk("fs_oe_released", 7'h00, fail_sync_pin_oe);
    chk("nv_reloaded", 7'h00, watchdog_input_action);
    $display("test hard watchdog done");
    nv_power_ok_mode = 1'b1;
    nv_power_ok_slot = 1'b1;
    sys_state = pmicpl_pkg::PMICPL_SYS_OFF;
    do_reset();
    chk("gpo_levels", 7'h03, {run_general_out_level, standby_general_out_level});
    chk("fs_oe_off", 7'h01, fail_sync_pin_oe);
    chk("pg_off", 7'h01, power_ok_out_oe);
    turn_on_ready = 1'b1;
    peer_hold = 1'b1;
    cyc(3);
    chk("fs_oe_ready", 7'h00, fail_sync_pin_oe);
    chk("stall_held", 7'h01, powerup_stall);
    peer_hold = 1'b0;
    sys_state = pmicpl_pkg::PMICPL_SYS_PWRUP;
    regulator_enable_in = 3'h2;
    mon = '{enabled: 3'h7, over: 3'h0, under: 3'h1};
    cyc(2);
    chk("stall_free", 7'h00, powerup_stall);
    chk("enable_frozen", 7'h05, regulator_on_request);
    chk("pg_pwrup", 7'h01, power_ok_out_oe);
    processor_reset_ready = 1'b1;
    cyc(1);
    chk("powerup_fault", 7'h01, powerup_fault);
    mon = '0;
    cyc(2);
    chk("pg_released", 7'h00, power_ok_out_oe);
    nv_power_ok_mode = 1'b0;
    sys_state = pmicpl_pkg::PMICPL_SYS_ON;
    gpo = '{write: 1'b1, run_level: 1'b0, standby_level: 1'b1};
    cyc(1);
    gpo = '0;
    cyc(1);
    chk("gpo_run", 7'h01, power_ok_out_oe);
    sys_state = pmicpl_pkg::PMICPL_SYS_STBY;
    cyc(2);
    chk("gpo_standby", 7'h00, power_ok_out_oe);
    $display("test power ok done");
    final_report();
  end
endmodule
